// ---- src/acmc_control.sv ----
// Converter control and status block with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module acmc_control
  import acmc_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire acmc_avm_req_t avs,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic          global_irq_enable,
  input  wire logic          irq_vector_ack,
  input  wire logic [7:0]    trigger_sources,
  input  wire logic [9:0]    core_result,
  output acmc_core_ctrl_t    core_ctrl,
  output logic               irq
);

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  acmc_ctl_state_t       q;
  acmc_ctl_state_t       n;
  acmc_route_t           sel_route;
  logic                  req;
  logic                  accept;
  logic                  wr;
  logic                  rd_capture;
  logic                  low_capture;
  logic [7:0]            rd_view;
  logic [7:0]            res_low;
  logic [7:0]            res_high;
  logic                  step;
  logic                  sel_trig;
  logic                  trig_edge;
  logic                  sw_start;
  logic                  flag_clr;
  logic                  flag_set;
  logic                  lock_now;
  logic                  begin_conv;
  logic [ACMC_EVT_W-1:0] evt_set;
  logic [ACMC_EVT_W-1:0] evt_clr;

  // ----------------------------------------------------------------
  // Leaf instances
  // ----------------------------------------------------------------
  acmc_prescaler u_prescaler (
    .clock   (clock),
    .rstn    (rstn),
    .clear   (q.st != ACMC_ST_CONV),
    .div_sel (q.ps),
    .tick    (step)
  );

  acmc_chan_decode u_chan_decode (
    .code  (n.input_sel[4:0]),
    .route (sel_route)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n           = q;
    n.sample    = 1'b0;
    sw_start    = 1'b0;
    flag_clr    = irq_vector_ack;
    flag_set    = 1'b0;
    evt_set     = '0;
    evt_clr     = '0;
    begin_conv  = 1'b0;

    // Bus handshake: one wait cycle, data captured in it
    req         = avs.read | avs.write;
    accept      = req & q.ack;
    n.ack       = req & ~q.ack;
    wr          = avs.write & accept & avs.byteenable[0];
    rd_capture  = avs.read & ~q.ack;
    low_capture = rd_capture & (avs.address == ACMC_OFS_RES_LOW);

    // Result view follows the left-adjust bit directly
    if (q.input_sel[ACMC_SEL_LADJ]) begin
      res_high = q.result[9:2];
      res_low  = {q.result[1:0], 6'h00};
    end else begin
      res_high = {6'h00, q.result[9:8]};
      res_low  = q.result[7:0];
    end

    case (avs.address)
      ACMC_OFS_INPUT_SEL:  rd_view = q.input_sel;
      ACMC_OFS_CTRL_A:     rd_view = {q.en, (q.st != ACMC_ST_IDLE), q.ate,
                                      q.flag, q.ie, q.ps};
      ACMC_OFS_CTRL_B:     rd_view = {5'h00, q.ts};
      ACMC_OFS_RES_LOW:    rd_view = res_low;
      ACMC_OFS_RES_HIGH:   rd_view = res_high;
      ACMC_OFS_EVT_STATUS: rd_view = {5'h00, q.evt};
      ACMC_OFS_EVT_MASK:   rd_view = {5'h00, q.mask};
      default:             rd_view = 8'h00;
    endcase

    if (rd_capture) begin
      n.rdata = {24'h000000, rd_view};
    end

    // Low byte read locks the result; high byte read releases it
    if (low_capture) begin
      n.lock = 1'b1;
    end
    if (avs.read && accept && avs.address == ACMC_OFS_RES_HIGH) begin
      n.lock = 1'b0;
    end
    lock_now = q.lock | low_capture;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (wr) begin
      case (avs.address)
        ACMC_OFS_INPUT_SEL: begin
          n.input_sel = avs.writedata[7:0];
        end
        ACMC_OFS_CTRL_A: begin
          n.en     = avs.writedata[ACMC_A_ENABLE];
          n.ate    = avs.writedata[ACMC_A_AUTO];
          n.ie     = avs.writedata[ACMC_A_IRQ_EN];
          n.ps     = avs.writedata[2:0];
          sw_start = avs.writedata[ACMC_A_START];
          flag_clr = flag_clr | avs.writedata[ACMC_A_FLAG];
        end
        ACMC_OFS_CTRL_B: begin
          n.ts = avs.writedata[2:0];
        end
        ACMC_OFS_EVT_STATUS: begin
          evt_clr = avs.writedata[ACMC_EVT_W-1:0];
        end
        ACMC_OFS_EVT_MASK: begin
          n.mask = avs.writedata[ACMC_EVT_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Auto trigger edge detection
    // ----------------------------------------------------------------
    if (q.ts == ACMC_TS_FREE) begin
      sel_trig = 1'b0;
    end else begin
      sel_trig = trigger_sources[q.ts];
    end
    n.trig_prev = sel_trig;
    trig_edge   = q.ate & sel_trig & ~q.trig_prev;

    // Selections reach the core only between conversions
    if (q.st != ACMC_ST_CONV) begin
      n.act_ref   = n.input_sel[7:6];
      n.act_route = sel_route;
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    case (q.st)
      ACMC_ST_IDLE: begin
        if (n.en && (sw_start || trig_edge)) begin
          begin_conv = 1'b1;
        end
      end
      ACMC_ST_CONV: begin
        if (step) begin
          if (q.cnt == q.len - 5'h01) begin
            n.st = ACMC_ST_DONE;
          end else begin
            n.cnt = q.cnt + 5'h01;
          end
        end
      end
      ACMC_ST_DONE: begin
        flag_set = 1'b1;
        evt_set[ACMC_EVT_DONE] = 1'b1;
        if (!lock_now) begin
          n.result = core_result;
        end else begin
          evt_set[ACMC_EVT_LOST] = 1'b1;
        end
        if (n.en && q.ate && q.ts == ACMC_TS_FREE) begin
          begin_conv = 1'b1;
        end else if (n.en && sw_start) begin
          begin_conv = 1'b1;
        end else begin
          n.st = ACMC_ST_IDLE;
        end
      end
      default: begin
        n.st = ACMC_ST_IDLE;
      end
    endcase

    if (begin_conv) begin
      n.st        = ACMC_ST_CONV;
      n.cnt       = 5'h00;
      n.len       = q.init_pend ? ACMC_INIT_CYCLES : ACMC_NORM_CYCLES;
      n.init_pend = 1'b0;
      n.sample    = 1'b1;
    end

    // Disabling stops everything and rearms the long first conversion
    if (!n.en) begin
      if (q.st == ACMC_ST_CONV) begin
        evt_set[ACMC_EVT_ABORT] = 1'b1;
      end
      n.st        = ACMC_ST_IDLE;
      n.cnt       = 5'h00;
      n.sample    = 1'b0;
      n.init_pend = 1'b1;
    end

    // Sticky flags: a set in the clearing cycle wins
    n.flag = (q.flag & ~flag_clr) | flag_set;
    n.evt  = (q.evt & ~evt_clr) | evt_set;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q           <= '0;
      q.input_sel <= ACMC_INPUT_SEL_RST;
      q.ps        <= ACMC_PS_RST;
      q.ts        <= ACMC_TS_RST;
      q.mask      <= ACMC_MASK_RST;
      q.st        <= ACMC_ST_IDLE;
      q.len       <= ACMC_NORM_CYCLES;
      q.init_pend <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest   = req & ~q.ack;
  assign avs_readdata      = q.rdata;
  assign core_ctrl.power   = q.en;
  assign core_ctrl.ref_sel = q.act_ref;
  assign core_ctrl.route   = q.act_route;
  assign core_ctrl.sample  = q.sample;
  assign core_ctrl.step    = step & (q.st == ACMC_ST_CONV);
  assign irq = (q.flag & q.ie & global_irq_enable) | (|(q.evt & q.mask));

endmodule // acmc_control
`default_nettype wire

// ---- src/acmc_pkg.sv ----
// Shared constants and types of the converter control block
package acmc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ACMC_OFS_INPUT_SEL  = 8'h00;
  localparam logic [7:0] ACMC_OFS_CTRL_A     = 8'h04;
  localparam logic [7:0] ACMC_OFS_CTRL_B     = 8'h08;
  localparam logic [7:0] ACMC_OFS_RES_LOW    = 8'h0C;
  localparam logic [7:0] ACMC_OFS_RES_HIGH   = 8'h10;
  localparam logic [7:0] ACMC_OFS_EVT_STATUS = 8'h14;
  localparam logic [7:0] ACMC_OFS_EVT_MASK   = 8'h18;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ACMC_A_ENABLE   = 7;
  localparam int ACMC_A_START    = 6;
  localparam int ACMC_A_AUTO     = 5;
  localparam int ACMC_A_FLAG     = 4;
  localparam int ACMC_A_IRQ_EN   = 3;
  localparam int ACMC_SEL_LADJ   = 5;
  localparam int ACMC_EVT_DONE   = 0;
  localparam int ACMC_EVT_LOST   = 1;
  localparam int ACMC_EVT_ABORT  = 2;
  localparam int ACMC_EVT_W      = 3;

  localparam logic [7:0] ACMC_INPUT_SEL_RST = 8'h00;
  localparam logic [2:0] ACMC_PS_RST        = 3'h0;
  localparam logic [2:0] ACMC_TS_RST        = 3'h0;
  localparam logic [2:0] ACMC_MASK_RST      = 3'h0;

  // ----------------------------------------------------------------
  // Codes and timing counts
  // ----------------------------------------------------------------
  localparam logic [1:0] ACMC_REF_EXTERNAL = 2'h0;
  localparam logic [1:0] ACMC_REF_SUPPLY   = 2'h1;
  localparam logic [1:0] ACMC_REF_RESERVED = 2'h2;
  localparam logic [1:0] ACMC_REF_BANDGAP  = 2'h3;
  localparam logic [4:0] ACMC_CH_BANDGAP   = 5'h1E;
  localparam logic [4:0] ACMC_CH_GROUND    = 5'h1F;
  localparam logic [2:0] ACMC_NEG_DIFF_A   = 3'h1;
  localparam logic [2:0] ACMC_NEG_DIFF_B   = 3'h2;
  localparam logic [2:0] ACMC_TS_FREE      = 3'h0;
  localparam logic [4:0] ACMC_INIT_CYCLES  = 5'h19;
  localparam logic [4:0] ACMC_NORM_CYCLES  = 5'h0D;

  // Last prescaler count per divider code: 1,1,3,7,15,31,63,127
  localparam logic [6:0] ACMC_DIV_LAST [8] = '{7'h01, 7'h01, 7'h03, 7'h07,
                                               7'h0F, 7'h1F, 7'h3F, 7'h7F};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ACMC_IN_NONE    = 3'h0,
    ACMC_IN_SINGLE  = 3'h1,
    ACMC_IN_DIFF    = 3'h2,
    ACMC_IN_BANDGAP = 3'h3,
    ACMC_IN_GROUND  = 3'h4
  } acmc_in_kind_t;

  typedef struct packed {
    acmc_in_kind_t kind;
    logic [2:0]    pos;
    logic [2:0]    neg;
  } acmc_route_t;

  typedef struct packed {
    logic        power;
    logic [1:0]  ref_sel;
    acmc_route_t route;
    logic        sample;
    logic        step;
  } acmc_core_ctrl_t;

  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } acmc_avm_req_t;

  typedef enum logic [1:0] {
    ACMC_ST_IDLE = 2'b00,
    ACMC_ST_CONV = 2'b01,
    ACMC_ST_DONE = 2'b11
  } acmc_state_t;

  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdata;
    logic [7:0]            input_sel;
    logic                  en;
    logic                  ate;
    logic                  flag;
    logic                  ie;
    logic [2:0]            ps;
    logic [2:0]            ts;
    acmc_state_t           st;
    logic [4:0]            cnt;
    logic [4:0]            len;
    logic                  init_pend;
    logic [1:0]            act_ref;
    acmc_route_t           act_route;
    logic                  trig_prev;
    logic [9:0]            result;
    logic                  lock;
    logic [ACMC_EVT_W-1:0] evt;
    logic [ACMC_EVT_W-1:0] mask;
    logic                  sample;
  } acmc_ctl_state_t;

  typedef struct packed {
    logic [6:0] cnt;
  } acmc_psc_state_t;

endpackage

// ---- src/acmc_prescaler.sv ----
// Converter clock prescaler producing one step pulse per converter clock
`timescale 1ns/1ps
`default_nettype none
module acmc_prescaler
  import acmc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       clear,
  input  wire logic [2:0] div_sel,
  output logic            tick
);

  acmc_psc_state_t q;
  acmc_psc_state_t n;
  logic [6:0]      last;

  always_comb begin
    n    = q;
    last = ACMC_DIV_LAST[div_sel];
    tick = ~clear & (q.cnt == last);
    if (clear || q.cnt == last) begin
      n.cnt = 7'h00;
    end else begin
      n.cnt = q.cnt + 7'h01;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule // acmc_prescaler
`default_nettype wire

// ---- src/acmc_chan_decode.sv ----
// Channel code decoder to analog multiplexer routing
`timescale 1ns/1ps
`default_nettype none
module acmc_chan_decode
  import acmc_pkg::*;
(
  input  wire logic [4:0] code,
  output acmc_route_t     route
);

  always_comb begin
    route.kind = ACMC_IN_NONE;
    route.pos  = code[2:0];
    route.neg  = 3'h0;
    if (code == ACMC_CH_BANDGAP) begin
      route.kind = ACMC_IN_BANDGAP;
    end else if (code == ACMC_CH_GROUND) begin
      route.kind = ACMC_IN_GROUND;
    end else if (code[4:3] == 2'h0) begin
      route.kind = ACMC_IN_SINGLE;
    end else if (code[4:3] == 2'h2) begin
      route.kind = ACMC_IN_DIFF;
      route.neg  = ACMC_NEG_DIFF_A;
    end else if (code[4:3] == 2'h3) begin
      route.kind = ACMC_IN_DIFF;
      route.neg  = ACMC_NEG_DIFF_B;
    end
  end

endmodule // acmc_chan_decode
`default_nettype wire

// ---- verif/acmc_control_properties.sv ----
// Port level checks of the converter control block
`timescale 1ns/1ps
`default_nettype none
module acmc_control_properties
  import acmc_pkg::*;
(
  input wire logic            clock,
  input wire logic            rstn,
  input wire acmc_avm_req_t   avs,
  input wire logic [31:0]     avs_readdata,
  input wire logic            avs_waitrequest,
  input wire logic            global_irq_enable,
  input wire logic            irq_vector_ack,
  input wire logic [7:0]      trigger_sources,
  input wire logic [9:0]      core_result,
  input wire acmc_core_ctrl_t core_ctrl,
  input wire logic            irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // Converter clock steps seen since the last sample pulse
  logic [5:0] steps_q;
  logic [5:0] steps_d;
  always_comb begin
    steps_d = steps_q;
    if (core_ctrl.sample) steps_d = {5'h00, core_ctrl.step};
    else if (core_ctrl.step) steps_d = steps_q + 6'h01;
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) steps_q <= 6'h00;
    else steps_q <= steps_d;
  end

  a_bus_wait: assert property ($rose(avs.read || avs.write) |-> avs_waitrequest)
    else $error("request taken without wait cycle");
  a_bus_answer: assert property ((avs.read || avs.write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_bus_idle: assert property (!(avs.read || avs.write) |-> !avs_waitrequest)
    else $error("wait asserted without request");
  a_read_upper: assert property (avs.read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_off_quiet: assert property (!core_ctrl.power |-> !(core_ctrl.step || core_ctrl.sample))
    else $error("converter active while powered off");
  a_sample_pulse: assert property (core_ctrl.sample |=> !core_ctrl.sample)
    else $error("sample pulse longer than one cycle");
  a_step_spacing: assert property (core_ctrl.step |=> !core_ctrl.step)
    else $error("converter clock faster than half system clock");
  a_sel_hold: assert property (core_ctrl.sample |=>
    (($stable(core_ctrl.route) && $stable(core_ctrl.ref_sel)) [*8]) or (##[0:7] !core_ctrl.power))
    else $error("selection changed during conversion");
  a_step_bound: assert property (steps_q <= 6'h19)
    else $error("conversion longer than initial length");

  c_sample: cover property (core_ctrl.sample);
  c_irq: cover property ($rose(irq));
  c_read: cover property (avs.read && !avs_waitrequest);
endmodule // acmc_control_properties

bind acmc_control acmc_control_properties u_props (
  .clock(clock), .rstn(rstn), .avs(avs), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .global_irq_enable(global_irq_enable),
  .irq_vector_ack(irq_vector_ack), .trigger_sources(trigger_sources),
  .core_result(core_result), .core_ctrl(core_ctrl), .irq(irq));
`default_nettype wire

// ---- verif/acmc_core_model.sv ----
// Behavioural model of the analog core behind the control block
`timescale 1ns/1ps
`default_nettype none
module acmc_core_model
  import acmc_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            rstn,
  input  wire acmc_core_ctrl_t core_ctrl,
  output logic [9:0]           core_result
);
  logic [9:0] code_q;
  // Result encodes the reference and route seen at the sample pulse
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      code_q <= 10'h000;
    end else if (core_ctrl.sample) begin
      code_q <= {core_ctrl.ref_sel, core_ctrl.route.pos, core_ctrl.route.kind[1:0], 3'h5};
    end
  end
  // Powered down core releases its output: show the inverse of the last code
  assign core_result = core_ctrl.power ? code_q : ~code_q;
endmodule // acmc_core_model
`default_nettype wire

// ---- verif/acmc_control_bench.sv ----
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module acmc_control_bench
  import acmc_pkg::*;
;
  logic            clock;
  logic            rstn;
  acmc_avm_req_t   avs;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest;
  logic            global_irq_enable;
  logic            irq_vector_ack;
  logic [7:0]      trigger_sources;
  logic [9:0]      core_result;
  acmc_core_ctrl_t core_ctrl;
  logic            irq;
  logic [7:0]      rd;
  int              n_errors;
  int              comparisons;
  int              n;

  always #5 clock = ~clock;

  acmc_control dut (.clock(clock), .rstn(rstn), .avs(avs), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .global_irq_enable(global_irq_enable),
    .irq_vector_ack(irq_vector_ack), .trigger_sources(trigger_sources),
    .core_result(core_result), .core_ctrl(core_ctrl), .irq(irq));
  acmc_core_model u_core (.clock(clock), .rstn(rstn), .core_ctrl(core_ctrl),
    .core_result(core_result));

  task summarize();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k;
    @(posedge clock);
    avs <= '{address: a, read: !w, write: w, writedata: {24'h000000, d}, byteenable: 4'hF};
    k = 0;
    do begin
      @(posedge clock);
      k++;
      if (k > 20) begin
        n_errors++;
        summarize();
      end
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs.read <= 1'b0;
    avs.write <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task rdc(input logic [7:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk({24'h000000, rd}, {24'h000000, e});
  endtask

  // Counts cycles until irq or a sample pulse shows, within a bound
  task wt(input logic on_irq, input int lim, input logic must, output int k);
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while ((on_irq ? irq : core_ctrl.sample) !== 1'b1 && k < lim);
    if (must && (on_irq ? irq : core_ctrl.sample) !== 1'b1) begin
      n_errors++;
      summarize();
    end
  endtask

  function automatic acmc_in_kind_t ek(input logic [4:0] c);
    if (c[4:3] == 2'h0) return ACMC_IN_SINGLE;
    if (c[4:3] == 2'h1) return ACMC_IN_NONE;
    if (c == 5'h1E) return ACMC_IN_BANDGAP;
    if (c == 5'h1F) return ACMC_IN_GROUND;
    return ACMC_IN_DIFF;
  endfunction

  function automatic logic [9:0] er(input logic [1:0] r, input logic [4:0] c);
    return {r, c[2:0], 2'h1, 3'h5};
  endfunction

  task res(input logic [9:0] r, input logic l);
    rdc(ACMC_OFS_RES_LOW, l ? {r[1:0], 6'h00} : r[7:0]);
    rdc(ACMC_OFS_RES_HIGH, l ? r[9:2] : {6'h00, r[9:8]});
  endtask

  task s_regs();
    rdc(ACMC_OFS_INPUT_SEL, ACMC_INPUT_SEL_RST);
    rdc(ACMC_OFS_CTRL_A, 8'h00);
    rdc(ACMC_OFS_CTRL_B, 8'h00);
    rdc(ACMC_OFS_EVT_MASK, 8'h00);
    wr(8'h1C, 8'hFF);
    rdc(8'h1C, 8'h00);
  endtask

  task s_route();
    logic [4:0] cc [10];
    acmc_in_kind_t kd;
    cc = '{5'h00, 5'h07, 5'h08, 5'h0F, 5'h10, 5'h17, 5'h18, 5'h1D, 5'h1E, 5'h1F};
    for (int k = 0; k < 10; k++) begin
      kd = ek(cc[k]);
      wr(ACMC_OFS_INPUT_SEL, {k[1:0], 1'b0, cc[k]});
      repeat (2) @(negedge clock);
      chk(core_ctrl.ref_sel, k[1:0]);
      chk(core_ctrl.route.kind, kd);
      if (kd == ACMC_IN_SINGLE || kd == ACMC_IN_DIFF) chk(core_ctrl.route.pos, cc[k][2:0]);
      if (kd == ACMC_IN_DIFF) chk(core_ctrl.route.neg, cc[k][3] ? 3'h2 : 3'h1);
    end
  endtask

  task s_conv1();
    @(posedge clock);
    global_irq_enable <= 1'b1;
    wr(ACMC_OFS_INPUT_SEL, 8'h45);
    wr(ACMC_OFS_CTRL_A, 8'hC9);
    wt(1'b1, 200, 1'b1, n);
    rdc(ACMC_OFS_CTRL_A, 8'h99);
    res(er(2'h1, 5'h05), 1'b0);
    wr(ACMC_OFS_INPUT_SEL, 8'h65);
    res(er(2'h1, 5'h05), 1'b1);
    @(posedge clock);
    global_irq_enable <= 1'b0;
    @(negedge clock);
    chk(irq, 1'b0);
    @(posedge clock);
    global_irq_enable <= 1'b1;
    irq_vector_ack <= 1'b1;
    @(posedge clock);
    irq_vector_ack <= 1'b0;
    @(negedge clock);
    chk(irq, 1'b0);
  endtask

  task s_conv2();
    wr(ACMC_OFS_CTRL_A, 8'hCB);
    wt(1'b0, 10, 1'b1, n);
    wr(ACMC_OFS_INPUT_SEL, 8'hC2);
    wr(ACMC_OFS_CTRL_A, 8'h8B);
    @(negedge clock);
    chk(core_ctrl.route.pos, 3'h5);
    chk(core_ctrl.ref_sel, 2'h1);
    rdc(ACMC_OFS_CTRL_A, 8'hCB);
    wt(1'b1, 300, 1'b1, n);
    rdc(ACMC_OFS_CTRL_A, 8'h9B);
    chk(core_ctrl.route.pos, 3'h2);
    chk(core_ctrl.ref_sel, 2'h3);
    res(er(2'h1, 5'h05), 1'b0);
    wr(ACMC_OFS_CTRL_A, 8'h9B);
    rdc(ACMC_OFS_CTRL_A, 8'h8B);
    chk(irq, 1'b0);
  endtask

  task s_abort();
    wr(ACMC_OFS_CTRL_A, 8'hC8);
    wt(1'b0, 10, 1'b1, n);
    wr(ACMC_OFS_CTRL_A, 8'h08);
    @(negedge clock);
    chk(core_ctrl.power, 1'b0);
    rdc(ACMC_OFS_CTRL_A, 8'h08);
    rdc(ACMC_OFS_EVT_STATUS, 8'h05);
    chk(irq, 1'b0);
    wr(ACMC_OFS_EVT_MASK, 8'h04);
    @(negedge clock);
    chk(irq, 1'b1);
    wr(ACMC_OFS_EVT_STATUS, 8'h05);
    @(negedge clock);
    chk(irq, 1'b0);
    wr(ACMC_OFS_EVT_MASK, 8'h00);
  endtask

  // Low byte read holds the old result through a completion
  task s_lock();
    logic [9:0] r;
    r = er(2'h1, 5'h05);
    wr(ACMC_OFS_INPUT_SEL, 8'hC3);
    rdc(ACMC_OFS_RES_LOW, r[7:0]);
    wr(ACMC_OFS_CTRL_A, 8'hD8);
    wt(1'b1, 200, 1'b1, n);
    rdc(ACMC_OFS_RES_HIGH, {6'h00, r[9:8]});
    rdc(ACMC_OFS_EVT_STATUS, 8'h03);
    wr(ACMC_OFS_CTRL_A, 8'hD8);
    wt(1'b1, 200, 1'b1, n);
    res(er(2'h3, 5'h03), 1'b0);
    wr(ACMC_OFS_EVT_STATUS, 8'h03);
    wr(ACMC_OFS_CTRL_A, 8'h10);
  endtask

  task s_auto();
    wr(ACMC_OFS_CTRL_B, 8'h02);
    wr(ACMC_OFS_CTRL_A, 8'hA8);
    @(posedge clock);
    trigger_sources <= 8'h04;
    wt(1'b0, 8, 1'b1, n);
    wt(1'b1, 100, 1'b1, n);
    chk(n, int'(ACMC_INIT_CYCLES) * 2 + 1);
    wr(ACMC_OFS_CTRL_B, 8'h00);
    wt(1'b0, 30, 1'b0, n);
    chk(n, 30);
    @(posedge clock);
    trigger_sources <= 8'h00;
  endtask

  task s_free();
    int d;
    for (int k = 0; k < 8; k++) begin
      d = (k < 2) ? 2 : (1 << k);
      wr(ACMC_OFS_CTRL_A, 8'h00);
      wr(ACMC_OFS_CTRL_A, {5'h1C, k[2:0]});
      wt(1'b0, 10, 1'b1, n);
      wt(1'b0, 3400, 1'b1, n);
      chk(n, int'(ACMC_INIT_CYCLES) * d + 1);
      wt(1'b0, 1700, 1'b1, n);
      chk(n, int'(ACMC_NORM_CYCLES) * d + 1);
    end
    wr(ACMC_OFS_CTRL_A, 8'h00);
  endtask

  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    avs = '0;
    global_irq_enable = 1'b0;
    irq_vector_ack = 1'b0;
    trigger_sources = 8'h00;
    n_errors = 0;
    comparisons = 0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    s_regs();
    s_route();
    s_conv1();
    s_conv2();
    s_abort();
    s_lock();
    s_auto();
    s_free();
    summarize();
  end
endmodule // acmc_control_bench
`default_nettype wire
